// ===== design/iepb_map.svh
// ============================================================
// register map and constants of the interrupt enable/priority bank
// assumes a 32-bit apb slave with word-aligned registers
//
// Notes on behaviour
// - in enable bank two, bits fifteen down to seven do nothing, read zero and drop writes.
// - an enable bit at one lets its source request through, at zero it blocks it.
// - bank two holds capture4, capture3, dma3 done, can event, can rx ready, spi2 event and spi2 error at bits 6 to 0.
// - without the can controller the can enable bits have no effect and those interrupts stay off.
// - bank three holds quad decoder 1 at bit 10 and pwm special match at bit 9, bits 15-11 and 8-7 read zero.
// - bank three holds ext irq4 at bit 6, ext irq3 at bit 5, i2c2 master at bit 2, i2c2 slave at bit 1, others zero.
// - bank four holds quad decoder 2 at bit 11, pwm secondary match error at bit 9 and can tx request at bit 6.
// - bank four holds uart2 error at bit 2 and uart1 error at bit 1, all other bits read zero.
// - bank five holds pwm2, pwm1, adc pair 12 at bits 15-13 and adc pairs 11-8 at bits 4-1, others zero.
// - bank six holds adc pairs 1 and 0 at bits 15-14, comparators 4-2 at bits 9-7, pwm 9-3 at bits 6-0.
// - bank seven holds adc pairs 7 to 2 at bits 5 to 0, bits 15-6 read zero.
// - priority register 0 holds 3-bit levels for timer1, out compare1, capture1 and ext irq0, gap bits read zero.
// - a priority field of 7 is highest, 1 is lowest, 0 disables the source.
// - at reset every enable bit clears and every priority field loads level four.
// - each source has a flag that reads one once its request has occurred, whatever its enable; the enable gates only the forwarded request.
// ============================================================
`ifndef IEPB_MAP_SVH
`define IEPB_MAP_SVH

// register byte offsets
`define IEPB_EN_BASE 8'h00
`define IEPB_PRIO0_OFF 8'h18
`define IEPB_FLAG_BASE 8'h20
`define IEPB_CLR_BASE 8'h40
`define IEPB_PFLAG_OFF 8'h60
`define IEPB_PCLR_OFF 8'h64

// implemented bits per enable bank
`define IEPB_MASK_BANK2 16'h007F
`define IEPB_MASK_BANK3 16'h0666
`define IEPB_MASK_BANK4 16'h0A46
`define IEPB_MASK_BANK5 16'hE01E
`define IEPB_MASK_BANK6 16'hC3FF
`define IEPB_MASK_BANK7 16'h003F

// can-related bits
`define IEPB_CAN_BANK2 16'h000C
`define IEPB_CAN_BANK4 16'h0040

// priority register layout and reset
`define IEPB_PRIO_MASK 16'h7777
`define IEPB_PRIO_RESET 16'h4444
`define IEPB_EN_RESET 16'h0000

`endif

// ===== design/iepb_pkg.sv
// ============================================================
// types of the interrupt enable/priority bank
// assumes iepb_map.svh supplies the constants
// ============================================================
package iepb_pkg;

  // six enable banks, numbered 2 to 7 in software
  typedef logic [5:0][15:0] iepb_bank_type;

  // whole state of the block
  typedef struct packed {
    iepb_bank_type en;
    iepb_bank_type flag;
    logic [15:0] prio;
    logic [3:0] pflag;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    iepb_bank_type fwd;
    logic irq;
    logic [3:0] preq;
    logic [2:0] plevel;
  } iepb_state_type;

endpackage

// ===== design/iepb_top.sv
// ============================================================
// interrupt enable banks 2-7 and priority register 0, apb slave
// assumes sources and core arbitration run on pclk; request inputs are level or pulse, same domain
// ============================================================
`timescale 1ns/100ps
`include "iepb_map.svh"

module iepb_top
  import iepb_pkg::*;
#(
  parameter logic HAS_CAN = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral requests, bank 2 at index 0
  input wire logic [5:0][15:0] src_req,
  // timer1, out compare1, capture1, ext irq0 requests at bits 3..0
  input wire logic [3:0] prio_src_req,
  input wire logic [3:0] prio_src_en,
  // towards core arbitration
  output logic [5:0][15:0] irq_fwd,
  output logic [3:0] prio_fwd,
  output logic [2:0] prio_level,
  output logic irq
);

  // ============================================================
  // helpers

  // implemented and writable bits of one bank
  function automatic logic [15:0] bank_mask(input int unsigned idx);
    logic [15:0] m;
    logic [15:0] can;
    m = 16'h0000;
    can = 16'h0000;
    case (idx)
      0: begin
        m = `IEPB_MASK_BANK2;
        can = `IEPB_CAN_BANK2;
      end
      1: m = `IEPB_MASK_BANK3;
      2: begin
        m = `IEPB_MASK_BANK4;
        can = `IEPB_CAN_BANK4;
      end
      3: m = `IEPB_MASK_BANK5;
      4: m = `IEPB_MASK_BANK6;
      5: m = `IEPB_MASK_BANK7;
      default: m = 16'h0000;
    endcase
    bank_mask = HAS_CAN ? m : (m & ~can);
  endfunction

  // 3-bit priority field of source i
  function automatic logic [2:0] prio_field(input logic [15:0] p, input int unsigned i);
    prio_field = p[4*i +: 3];
  endfunction

  // ============================================================
  // state

  iepb_state_type cur;
  iepb_state_type next_cur;

  logic acc;
  logic wr;
  logic [5:0] word;
  logic [5:0] fl_idx;
  logic [5:0] cl_idx;

  // access phase and completing write
  assign acc = psel & penable & ~cur.pready;
  assign wr = psel & penable & cur.pready & pwrite;
  assign word = paddr[7:2];
  assign fl_idx = word - 6'(`IEPB_FLAG_BASE >> 2);
  assign cl_idx = word - 6'(`IEPB_CLR_BASE >> 2);

  // next state
  always_comb begin
    logic [3:0] pcand;
    logic [2:0] best;
    logic hit;
    logic [31:0] rd;
    pcand = 4'h0;
    best = 3'h0;
    hit = 1'b0;
    rd = 32'h0000_0000;
    next_cur = cur;

    // read decode, one wait state
    if (word < 6'h06) begin
      hit = 1'b1;
      rd = {16'h0000, cur.en[word[2:0]]};
    end else if (word == 6'(`IEPB_PRIO0_OFF >> 2)) begin
      hit = 1'b1;
      rd = {16'h0000, cur.prio};
    end else if (word >= 6'(`IEPB_FLAG_BASE >> 2) && fl_idx < 6'h06) begin
      hit = 1'b1;
      rd = {16'h0000, cur.flag[fl_idx[2:0]]};
    end else if (word >= 6'(`IEPB_CLR_BASE >> 2) && cl_idx < 6'h06) begin
      hit = 1'b1;
    end else if (word == 6'(`IEPB_PFLAG_OFF >> 2)) begin
      hit = 1'b1;
      rd = {28'h000_0000, cur.pflag};
    end else if (word == 6'(`IEPB_PCLR_OFF >> 2)) begin
      hit = 1'b1;
    end
    next_cur.pready = acc;
    if (acc) begin
      next_cur.prdata = pwrite ? 32'h0000_0000 : rd;
      next_cur.pslverr = ~hit;
    end else begin
      next_cur.prdata = 32'h0000_0000;
      next_cur.pslverr = 1'b0;
    end

    for (int i = 0; i < 6; i++) begin
      logic [15:0] clr;
      clr = 16'h0000;
      if (wr && word >= 6'(`IEPB_CLR_BASE >> 2) && cl_idx == 6'(i))
        clr = pwdata[15:0];
      next_cur.flag[i] = ((cur.flag[i] & ~clr) | src_req[i]) & bank_mask(i);
    end
    if (wr && word == 6'(`IEPB_PCLR_OFF >> 2))
      next_cur.pflag = (cur.pflag & ~pwdata[3:0]) | prio_src_req;
    else
      next_cur.pflag = cur.pflag | prio_src_req;

    for (int i = 0; i < 6; i++) begin
      if (wr && word == 6'(i))
        next_cur.en[i] = pwdata[15:0] & bank_mask(i);
    end
    if (wr && word == 6'(`IEPB_PRIO0_OFF >> 2))
      next_cur.prio = pwdata[15:0] & `IEPB_PRIO_MASK;

    for (int i = 0; i < 6; i++)
      next_cur.fwd[i] = cur.flag[i] & cur.en[i] & bank_mask(i);
    next_cur.irq = |next_cur.fwd;

    for (int i = 0; i < 4; i++) begin
      pcand[i] = cur.pflag[i] & prio_src_en[i] & (prio_field(cur.prio, i) != 3'h0);
      if (pcand[i] && prio_field(cur.prio, i) > best)
        best = prio_field(cur.prio, i);
    end
    next_cur.preq = pcand;
    next_cur.plevel = best;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.prio <= `IEPB_PRIO_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign irq_fwd = cur.fwd;
  assign prio_fwd = cur.preq;
  assign prio_level = cur.plevel;
  assign irq = cur.irq;

endmodule

// ===== tb/iepb_chk.sv
// assertions on the apb side and outputs
// assumes a bind into iepb_top
`timescale 1ns/100ps
module iepb_chk
  import iepb_pkg::*;
(
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // outputs
  input wire logic [5:0][15:0] irq_fwd,
  input wire logic [3:0] prio_fwd,
  input wire logic [2:0] prio_level,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // apb answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_ready_wait: assert property (s_wait |=> pready) else $error("no ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  // ==========
  // outputs
  a_irq_any: assert property (irq == (|irq_fwd)) else $error("irq mismatch");
  a_bank_gaps: assert property ((irq_fwd[0] & 16'hFF80) == 16'h0) else $error("gap fwd");
  a_level_fwd: assert property ((prio_level != 3'h0) == (prio_fwd != 4'h0)) else $error("bad level");
  a_prio_gaps: assert property (pready && !pwrite && paddr == 8'h18 |-> (prdata & 32'hFFFF8888) == 32'h0)
    else $error("gap bits");
endmodule

// ===== tb/iepb_src_model.sv
// peripheral request source model
// assumes go changes just after a pclk edge
`timescale 1ns/100ps
module iepb_src_model (
  // clock
  input wire logic pclk,
  // command
  input wire logic go,
  input wire logic [2:0] bank,
  input wire logic [3:0] bitn,
  // requests
  output logic [5:0][15:0] src_req
);
  initial src_req = '0;
  // ==========
  // one-cycle request
  always @(posedge pclk) begin
    src_req <= '0;
    if (go) begin
      src_req[bank][bitn] <= 1'b1;
    end
  end
endmodule

// ===== tb/iepb_top_test.sv
// self-checking bench of the enable and priority banks
// assumes the model and checker compile first
`timescale 1ns/100ps
module iepb_top_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, pready, pslverr, irq, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0][15:0] src_req, irq_fwd;
  logic [3:0] prio_src_req = 4'h0, prio_src_en = 4'h0, prio_fwd, bitn = 4'h0;
  logic [2:0] prio_level, bank = 3'h0;
  logic [15:0] masks [6] = '{16'h007F, 16'h0666, 16'h0A46, 16'hE01E, 16'hC3FF, 16'h003F};
  int error_cnt = 0, n_tests = 0, cyc = 0;
  iepb_top u_iepb_top (.*);
  iepb_src_model u_iepb_src_model (.*);
  // ==========
  // clock, timeout
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task fire(input logic [2:0] b, input logic [3:0] n);
    @(posedge pclk);
    bank <= b;
    bitn <= n;
    go <= 1;
    @(posedge pclk);
    go <= 0;
  endtask
  // ==========
  // scenarios
  task t_masks();
    apb(0, 8'h18, 0);
    chk("prio reset", 32'h4444, rd);
    for (int i = 0; i < 6; i++) begin
      apb(0, 8'(4 * i), 0);
      chk("en reset", 0, rd);
      apb(1, 8'(4 * i), 32'hFFFFFFFF);
      apb(0, 8'(4 * i), 0);
      chk("en mask", {16'h0, masks[i]}, rd);
      apb(1, 8'(4 * i), 0);
    end
    apb(1, 8'h18, 32'hFFFFFFFF);
    apb(0, 8'h18, 0);
    chk("prio mask", 32'h7777, rd);
    apb(0, 8'h80, 0);
    chk("unmapped", 1, err);
  endtask
  task t_gate();
    fire(0, 6);
    fire(0, 7);
    apb(0, 8'h20, 0);
    chk("flag", 32'h40, rd);
    chk("irq off", 0, irq);
    apb(1, 8'h00, 32'h40);
    repeat (3) @(posedge pclk);
    chk("fwd", 16'h0040, irq_fwd[0]);
    chk("irq on", 1, irq);
    apb(1, 8'h40, 32'h40);
    repeat (3) @(posedge pclk);
    chk("irq clr", 0, irq);
  endtask
  task t_prio();
    apb(1, 8'h18, 32'h7000);
    @(posedge pclk);
    prio_src_en <= 4'hF;
    prio_src_req <= 4'h9;
    @(posedge pclk);
    prio_src_req <= 4'h0;
    repeat (2) @(posedge pclk);
    chk("prio fwd", 4'h8, prio_fwd);
    chk("prio level", 3'h7, prio_level);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_masks();
    t_gate();
    t_prio();
    stop_test();
  end
endmodule
bind iepb_top iepb_chk u_iepb_chk (.*);
